// ---- hw/acm_pkg.sv ----
// package of the audio clock fault masking block: offsets, layouts, counts
// assumes a single 250 MHz clock and 32-bit AXI4-Lite register access
package acm_pkg;

   // clock rate and missing-clock time base
   localparam int unsigned CLK_MHZ        = 250;
   localparam int unsigned MISS_UNIT_MS   = 1000;  // one step of the timeout
   localparam int unsigned MISS_UNIT_CYC  = MISS_UNIT_MS * CLK_MHZ * 1000;

   // bit clock per frame clock window, inclusive
   localparam int unsigned SCLK_MIN       = 32;
   localparam int unsigned SCLK_MAX       = 256;

   // register map, byte addresses on a 12-bit window
   localparam int unsigned ADDR_W         = 12;
   localparam logic [7:0]  CTRL_IDX       = 8'h25;
   localparam logic [11:0] ADDR_CTRL      = {2'h0, CTRL_IDX, 2'h0};
   localparam logic [11:0] ADDR_STATUS    = 12'h000;
   localparam logic [11:0] ADDR_EVENT     = 12'h004;
   localparam logic [11:0] ADDR_MASK      = 12'h008;
   localparam logic [11:0] ADDR_MISS      = 12'h00C;
   localparam logic [11:0] ADDR_DIVM      = 12'h010;

   // values after reset
   localparam logic [7:0]  CTRL_RST       = 8'h00;
   localparam logic [3:0]  MASK_RST       = 4'h0;
   localparam logic [3:0]  EVENT_RST      = 4'h0;
   localparam logic [2:0]  MISS_RST       = 3'h0;
   localparam logic [7:0]  DIVM_RST       = 8'h00;

   // live status field positions
   localparam int unsigned ST_CLK_ERR     = 0;
   localparam int unsigned ST_PDN         = 1;
   localparam int unsigned ST_PLL_LOCK    = 2;
   localparam int unsigned ST_AUTOSET     = 3;
   localparam int unsigned ST_SCLK_ERR    = 4;
   localparam int unsigned ST_MISSING     = 5;

   // bus answers
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_DECERR    = 2'h3;

   // layout of the control byte, msb first
   typedef struct packed {
      logic rsv;
      logic ign_fs;
      logic ign_sclk;
      logic ign_mclk;
      logic ign_halt;
      logic ign_miss;
      logic autoset_dis;
      logic ign_pll;
   } acm_ctrl_t;

   // detector faults before masking
   typedef struct packed {
      logic fs;
      logic sclk;
      logic mclk;
      logic halt;
      logic pll;
   } acm_fault_t;

   // register selected by an address
   typedef enum logic [2:0] {
      REG_NONE, REG_STATUS, REG_EVENT, REG_MASK, REG_MISS, REG_DIVM, REG_CTRL
   } acm_reg_t;

endpackage

// ---- hw/acm_sclk_ratio.sv ----
// bit clock against frame clock ratio checker
// assumes sclk and lrck are synchronous samples in the aclk domain
`timescale 1ns/1ns
module acm_sclk_ratio #(
   parameter int unsigned CNT_W = 10
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic sclk,
   input  wire logic lrck,
   output logic      ratio_err_r
);
   localparam logic [CNT_W-1:0] CNT_MAX = '1;
   localparam logic [CNT_W-1:0] LO = CNT_W'(acm_pkg::SCLK_MIN);
   localparam logic [CNT_W-1:0] HI = CNT_W'(acm_pkg::SCLK_MAX);

   logic             sclk_d_r;
   logic             lrck_d_r;
   logic [CNT_W-1:0] cnt_r;
   logic             sclk_rise;
   logic             lrck_rise;

   assign sclk_rise = sclk & ~sclk_d_r;
   assign lrck_rise = lrck & ~lrck_d_r;

   // previous samples for edge finding
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sclk_d_r <= 1'b0;
         lrck_d_r <= 1'b0;
      end else begin
         sclk_d_r <= sclk;
         lrck_d_r <= lrck;
      end
   end

   // bit clock edges in one frame, saturating
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= '0;
      end else if (lrck_rise) begin
         cnt_r <= {{(CNT_W-1){1'b0}}, sclk_rise};
      end else if (sclk_rise && cnt_r != CNT_MAX) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   // judged once per frame, held until the next frame
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ratio_err_r <= 1'b0;
      end else if (lrck_rise) begin
         ratio_err_r <= (cnt_r < LO) || (cnt_r > HI);
      end
   end
endmodule

// ---- hw/acm_clock_mask.sv ----
// audio clock fault masking and divider autoset control, AXI4-Lite slave
// assumes all detector inputs and audio clock samples are synchronous
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ns
// Functional notes
// - sample rate fault raises clock error unless its ignore bit is set.
// - bit clocks per frame clock must stay within 32 to 256, else error.
// - bit clock error raises no clock error while its ignore bit is active.
// - master clock ratio fault raises clock error unless its ignore bit set.
// - master clock halt raises clock error unless its ignore bit is one.
// - missing bit and frame clocks power the DAC down unless ignored.
// - autoset enabled picks dividers automatically; disabled uses software values.
// - PLL unlock raises clock error unless the PLL ignore bit is one.
// - the PLL lock flag always shows the true lock state.
// - missing timeout selects one to eight seconds in three bits.
module acm_clock_mask #(
   parameter int unsigned DIV_W         = 8,
   parameter int unsigned MISS_UNIT_CYC = acm_pkg::MISS_UNIT_CYC
) (
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   // write address channel
   input  wire logic [acm_pkg::ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic [2:0]                  s_axi_awprot,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   // write data channel
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   // write response channel
   output logic [1:0]                       s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   // read address channel
   input  wire logic [acm_pkg::ADDR_W-1:0]  s_axi_araddr,
   input  wire logic [2:0]                  s_axi_arprot,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   // read data channel
   output logic [31:0]                      s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   // audio clock samples and detector results
   input  wire logic                        sclk,
   input  wire logic                        lrck,
   input  wire logic                        fs_fault,
   input  wire logic                        mclk_ratio_fault,
   input  wire logic                        mclk_halt_fault,
   input  wire logic                        pll_locked,
   input  wire logic [DIV_W-1:0]            auto_divider,
   // results
   output logic                             clk_error,
   output logic                             dac_powerdown,
   output logic                             pll_lock_flag,
   output logic                             autoset_active,
   output logic [DIV_W-1:0]                 divider_value,
   output logic                             irq
);

   // address decode shared by the read and write paths
   function automatic acm_pkg::acm_reg_t reg_sel(
      input logic [acm_pkg::ADDR_W-1:0] addr
   );
      unique case ({addr[acm_pkg::ADDR_W-1:2], 2'b00})
         acm_pkg::ADDR_STATUS: reg_sel = acm_pkg::REG_STATUS;
         acm_pkg::ADDR_EVENT:  reg_sel = acm_pkg::REG_EVENT;
         acm_pkg::ADDR_MASK:   reg_sel = acm_pkg::REG_MASK;
         acm_pkg::ADDR_MISS:   reg_sel = acm_pkg::REG_MISS;
         acm_pkg::ADDR_DIVM:   reg_sel = acm_pkg::REG_DIVM;
         acm_pkg::ADDR_CTRL:   reg_sel = acm_pkg::REG_CTRL;
         default:              reg_sel = acm_pkg::REG_NONE;
      endcase
   endfunction

   // software registers
   acm_pkg::acm_ctrl_t          ctrl_r;
   logic [3:0]                  mask_r;
   logic [3:0]                  event_r;
   logic [2:0]                  miss_sel_r;
   logic [DIV_W-1:0]            divm_r;
   // bus holding state
   logic [acm_pkg::ADDR_W-1:0]  aw_addr_r;
   logic                        aw_got_r;
   logic [31:0]                 w_data_r;
   logic                        w_strb0_r;
   logic                        w_got_r;
   logic                        wr_go;
   logic                        rd_go;
   acm_pkg::acm_reg_t           wr_sel;
   acm_pkg::acm_reg_t           rd_sel;
   // detector state
   logic                        sclk_err;
   acm_pkg::acm_fault_t         fault;
   logic [4:0]                  gate;
   logic                        clk_err_nxt;
   logic [31:0]                 miss_cnt_r;
   logic [31:0]                 miss_limit;
   logic                        missing_r;
   logic                        pdn_nxt;
   logic                        pll_lost;
   logic [3:0]                  ev_set;
   logic [5:0]                  status;

   // bit clock ratio check
   acm_sclk_ratio #(
      .CNT_W       (10)
   ) u_ratio (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .sclk        (sclk),
      .lrck        (lrck),
      .ratio_err_r (sclk_err)
   );

   // raw detector faults, unlock is the inverse of lock
   assign fault.fs   = fs_fault;
   assign fault.sclk = sclk_err;
   assign fault.mclk = mclk_ratio_fault;
   assign fault.halt = mclk_halt_fault;
   assign fault.pll  = ~pll_locked;
   // per fault ignore bits in fault order
   assign gate = {ctrl_r.ign_fs, ctrl_r.ign_sclk, ctrl_r.ign_mclk,
                  ctrl_r.ign_halt, ctrl_r.ign_pll};
   // each fault passes only while its ignore bit is clear
   genvar gi;
   logic [4:0] passed;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_gate
         assign passed[gi] = fault[gi] & ~gate[gi];
      end
   endgenerate
   // clock error is any passing fault
   assign clk_err_nxt = |passed;

   // registered clock error, refreshed every cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_error <= 1'b0;
      end else begin
         clk_error <= clk_err_nxt;
      end
   end

   // lock flag follows the lock input, never masked
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pll_lock_flag <= 1'b0;
      end else begin
         pll_lock_flag <= pll_locked;
      end
   end

   // timeout is (code + 1) seconds
   assign miss_limit = 32'(({29'h0, miss_sel_r} + 32'h1) * MISS_UNIT_CYC);

   // count cycles with both audio clocks low, any activity restarts
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         miss_cnt_r <= 32'h0;
         missing_r  <= 1'b0;
      end else if (sclk || lrck) begin
         miss_cnt_r <= 32'h0;
         missing_r  <= 1'b0;
      end else if (miss_cnt_r >= miss_limit - 32'h1) begin
         missing_r  <= 1'b1;
      end else begin
         miss_cnt_r <= miss_cnt_r + 32'h1;
      end
   end
   // powerdown only when missing and not ignored
   assign pdn_nxt = missing_r & ~ctrl_r.ign_miss;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dac_powerdown <= 1'b0;
      end else begin
         dac_powerdown <= pdn_nxt;
      end
   end

   // automatic divider unless autoset is disabled
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         divider_value  <= '0;
         autoset_active <= 1'b0;
      end else begin
         autoset_active <= ~ctrl_r.autoset_dis;
         if (ctrl_r.autoset_dis) begin
            divider_value <= divm_r;
         end else begin
            divider_value <= auto_divider;
         end
      end
   end

   // rising edges of the watched conditions
   assign pll_lost = pll_lock_flag & ~pll_locked;
   assign ev_set   = {sclk_err & ~status[acm_pkg::ST_SCLK_ERR],
                      pll_lost,
                      pdn_nxt & ~dac_powerdown,
                      clk_err_nxt & ~clk_error};
   // sticky bits, a read clears, a new event wins over the clear
   generate
      for (gi = 0; gi < 4; gi++) begin : g_event
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               event_r[gi] <= acm_pkg::EVENT_RST[gi];
            end else if (ev_set[gi]) begin
               event_r[gi] <= 1'b1;
            end else if (rd_go && rd_sel == acm_pkg::REG_EVENT) begin
               event_r[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // level interrupt while an unmasked event is pending
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(event_r & mask_r);
      end
   end

   // sclk ratio state of the previous cycle for edge finding
   logic sclk_err_d_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sclk_err_d_r <= 1'b0;
      end else begin
         sclk_err_d_r <= sclk_err;
      end
   end

   // live status word
   always_comb begin
      status                          = '0;
      status[acm_pkg::ST_CLK_ERR]     = clk_error;
      status[acm_pkg::ST_PDN]         = dac_powerdown;
      status[acm_pkg::ST_PLL_LOCK]    = pll_lock_flag;
      status[acm_pkg::ST_AUTOSET]     = autoset_active;
      status[acm_pkg::ST_SCLK_ERR]    = sclk_err_d_r;
      status[acm_pkg::ST_MISSING]     = missing_r;
   end

   // write path: both halves held and no response pending
   assign wr_go  = aw_got_r & w_got_r & ~s_axi_bvalid;
   assign wr_sel = reg_sel(aw_addr_r);

   // address and data taken in either order, held until the response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         aw_got_r      <= 1'b0;
         aw_addr_r     <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         aw_got_r      <= 1'b1;
         aw_addr_r     <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_got_r      <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b1;
         w_got_r      <= 1'b0;
         w_data_r     <= 32'h0;
         w_strb0_r    <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_got_r      <= 1'b1;
         w_data_r     <= s_axi_wdata;
         w_strb0_r    <= s_axi_wstrb[0];
      end else if (wr_go) begin
         w_got_r      <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end
   end

   // response one cycle after both halves are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= acm_pkg::RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (wr_sel == acm_pkg::REG_NONE) ?
                         acm_pkg::RESP_DECERR : acm_pkg::RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // register writes, byte lane 0 only; status and events are read only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r     <= acm_pkg::CTRL_RST;
         mask_r     <= acm_pkg::MASK_RST;
         miss_sel_r <= acm_pkg::MISS_RST;
         divm_r     <= DIV_W'(acm_pkg::DIVM_RST);
      end else if (wr_go && w_strb0_r) begin
         unique case (wr_sel)
            acm_pkg::REG_CTRL: begin
               ctrl_r     <= {1'b0, w_data_r[6:0]};
            end
            acm_pkg::REG_MASK: begin
               mask_r     <= w_data_r[3:0];
            end
            acm_pkg::REG_MISS: begin
               miss_sel_r <= w_data_r[2:0];
            end
            acm_pkg::REG_DIVM: begin
               divm_r     <= w_data_r[DIV_W-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // read path handshake and decode
   assign rd_go  = s_axi_arvalid & s_axi_arready;
   assign rd_sel = reg_sel(s_axi_araddr);

   // one read at a time, data one cycle after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= acm_pkg::RESP_OKAY;
      end else if (rd_go) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= acm_pkg::RESP_OKAY;
         unique case (rd_sel)
            acm_pkg::REG_STATUS: s_axi_rdata <= {26'h0, status};
            acm_pkg::REG_EVENT:  s_axi_rdata <= {28'h0, event_r};
            acm_pkg::REG_MASK:   s_axi_rdata <= {28'h0, mask_r};
            acm_pkg::REG_MISS:   s_axi_rdata <= {29'h0, miss_sel_r};
            acm_pkg::REG_DIVM:   s_axi_rdata <= 32'(divm_r);
            acm_pkg::REG_CTRL:   s_axi_rdata <= {24'h0, ctrl_r};
            default: begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= acm_pkg::RESP_DECERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule

// ---- dv/acm_clock_mask_asserts.sv ----
// checker for the clock fault masking block
// assumes one clock domain, synchronous active-low reset
`timescale 1ns/1ns
module acm_clock_mask_chk #(
   parameter int unsigned DIV_W = 8
) (
   input wire logic             aclk,
   input wire logic             aresetn,
   input wire logic [11:0]      s_axi_awaddr,
   input wire logic             s_axi_awvalid,
   input wire logic             s_axi_awready,
   input wire logic [31:0]      s_axi_wdata,
   input wire logic [3:0]       s_axi_wstrb,
   input wire logic             s_axi_wvalid,
   input wire logic             s_axi_wready,
   input wire logic             s_axi_bvalid,
   input wire logic             fs_fault,
   input wire logic             mclk_ratio_fault,
   input wire logic             mclk_halt_fault,
   input wire logic             pll_locked,
   input wire logic             sclk,
   input wire logic             lrck,
   input wire logic [DIV_W-1:0] auto_divider,
   input wire logic             clk_error,
   input wire logic             dac_powerdown,
   input wire logic             pll_lock_flag,
   input wire logic             autoset_active,
   input wire logic [DIV_W-1:0] divider_value,
   input wire logic             irq
);
   logic [11:0]        wa_r;
   logic [8:0]         wd_r;
   logic               bv_r;
   logic               ok_r;
   acm_pkg::acm_ctrl_t sh_r;
   logic               calm;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // mirror of the control byte, taken from the write in flight
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wa_r <= 12'h000;
         wd_r <= 9'h000;
         bv_r <= 1'h0;
         ok_r <= 1'h0;
         sh_r <= acm_pkg::CTRL_RST;
      end else begin
         bv_r <= s_axi_bvalid;
         ok_r <= 1'h1;
         if (s_axi_awvalid && s_axi_awready) wa_r <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready)
            wd_r <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
         if (s_axi_bvalid && !bv_r && wa_r == acm_pkg::ADDR_CTRL && wd_r[8])
            sh_r <= acm_pkg::acm_ctrl_t'({1'b0, wd_r[6:0]});
      end
   end
   // no write answer near, mirror is current
   assign calm = ok_r && !s_axi_bvalid && !bv_r;
   a_fs_raise: assert property (calm && $past(fs_fault && !sh_r.ign_fs)
      |-> clk_error) else $error("fs fault gave no clock error");
   a_mclk_raise: assert property (calm && $past(mclk_ratio_fault &&
      !sh_r.ign_mclk) |-> clk_error) else $error("mclk fault lost");
   a_halt_raise: assert property (calm && $past(mclk_halt_fault &&
      !sh_r.ign_halt) |-> clk_error) else $error("halt fault lost");
   a_pll_raise: assert property (calm && $past(!pll_locked && !sh_r.ign_pll)
      |-> clk_error) else $error("unlock gave no clock error");
   a_err_cause: assert property (calm && clk_error |-> $past(!sh_r.ign_sclk
      || (fs_fault && !sh_r.ign_fs) || (!pll_locked && !sh_r.ign_pll)
      || (mclk_ratio_fault && !sh_r.ign_mclk)
      || (mclk_halt_fault && !sh_r.ign_halt)))
      else $error("clock error without cause");
   a_lock_copy: assert property (ok_r |-> pll_lock_flag == $past(pll_locked))
      else $error("lock flag differs from lock");
   a_autoset_map: assert property (calm |->
      autoset_active == !$past(sh_r.autoset_dis))
      else $error("autoset state wrong");
   a_auto_div: assert property (calm && !$past(sh_r.autoset_dis) |->
      divider_value == $past(auto_divider))
      else $error("automatic divider not used");
   a_pdn_clocks: assert property ((sclk || lrck)[*3] |=> !dac_powerdown)
      else $error("powerdown with clocks present");
   a_pdn_ignore: assert property ((calm && sh_r.ign_miss)[*3]
      |=> !dac_powerdown) else $error("ignored missing powered down");
   c_err: cover property ($rose(clk_error));
   c_pdn: cover property ($rose(dac_powerdown));
   c_irq: cover property ($rose(irq));
endmodule
bind acm_clock_mask acm_clock_mask_chk #(.DIV_W(DIV_W)) acm_clock_mask_chk_inst (
   .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .fs_fault, .mclk_ratio_fault, .mclk_halt_fault, .pll_locked, .sclk, .lrck,
   .auto_divider, .clk_error, .dac_powerdown, .pll_lock_flag,
   .autoset_active, .divider_value, .irq);

// ---- dv/acm_audio_src.sv ----
// serial audio source model: bit and frame clocks in the aclk domain
// assumes the bench sets bit clocks per frame and the run enable
`timescale 1ns/1ns
module acm_audio_src (
   input  wire logic       aclk,
   input  wire logic       run,
   input  wire logic [9:0] bits,
   output logic            sclk,
   output logic            lrck
);
   logic [10:0] ph_r;
   // bit clock toggles each cycle; both clocks stand low when stopped
   always_ff @(posedge aclk) begin
      if (!run) begin
         ph_r <= 11'h000;
         sclk <= 1'h0;
         lrck <= 1'h0;
      end else begin
         ph_r <= (ph_r >= {bits, 1'h0} - 11'h001) ? 11'h000 : ph_r + 11'h001;
         sclk <= ph_r[0];
         lrck <= ph_r < {1'h0, bits};
      end
   end
endmodule

// ---- dv/tb_top.sv ----
// bench for the clock fault masking block with its audio source model
// assumes the checker binds itself; one 250 MHz clock
`timescale 1ns/1ns
module tb_top;
   typedef struct packed {
      logic [7:0] ctrl;
      logic [3:0] flt;
      logic       err;
   } acm_row_t;
   logic        aclk = 1'h0, aresetn = 1'h0, run = 1'h0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic        arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [1:0]  bresp, rresp, rs;
   logic        awready, wready, bvalid, arready, rvalid, sclk, lrck;
   logic [3:0]  st = 4'hF, flt = 4'h0; // flt: fs, mclk ratio, halt, unlock
   logic [9:0]  bits = 10'h040;
   logic        clk_error, dac_powerdown, pll_lock_flag, autoset_active, irq;
   logic [7:0]  divider_value;
   int          failures = 0, samples_checked = 0;
   acm_row_t rows [11] = '{'{8'h00, 4'h0, 1'h0}, '{8'h00, 4'h8, 1'h1},
      '{8'h40, 4'h8, 1'h0}, '{8'h00, 4'h4, 1'h1}, '{8'h10, 4'h4, 1'h0},
      '{8'h00, 4'h2, 1'h1}, '{8'h08, 4'h2, 1'h0}, '{8'h00, 4'h1, 1'h1},
      '{8'h01, 4'h1, 1'h0}, '{8'h5B, 4'hF, 1'h0}, '{8'h02, 4'h0, 1'h0}};
   logic [9:0] sb [5] = '{10'h01F, 10'h020, 10'h100, 10'h101, 10'h01F};
   logic       se [5] = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h0};
   always #2 aclk = ~aclk;
   acm_clock_mask #(.DIV_W(8), .MISS_UNIT_CYC(50)) acm_clock_mask_inst (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(st), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .sclk(sclk), .lrck(lrck), .fs_fault(flt[3]), .mclk_ratio_fault(flt[2]),
      .mclk_halt_fault(flt[1]), .pll_locked(!flt[0]), .auto_divider(8'hA5),
      .clk_error(clk_error), .dac_powerdown(dac_powerdown),
      .pll_lock_flag(pll_lock_flag), .autoset_active(autoset_active),
      .divider_value(divider_value), .irq(irq));
   acm_audio_src acm_audio_src_inst (.aclk(aclk), .run(run), .bits(bits),
      .sclk(sclk), .lrck(lrck));
   // compare and count
   task automatic chk(input string n, input logic [31:0] s, e);
      samples_checked++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   // one bus write, response code left in rs
   task automatic axw(input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (!bvalid && n < 200);
      rs = bresp;
      bready <= 1'h0;
      if (n >= 200) failures++;
   endtask
   // one bus read, word in rd and response in rs
   task automatic axr(input logic [11:0] a);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 1'h0;
      end while (!rvalid && n < 200);
      rd = rdata;
      rs = rresp;
      rready <= 1'h0;
      if (n >= 200) failures++;
   endtask
   // counts and verdict, then stop
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (30000) @(posedge aclk);
      failures++;
      print_verdict;
   end
   // main sequence
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      run <= 1'h1;
      axr(acm_pkg::ADDR_CTRL);
      chk("ctrl_rst", rd, 32'h0);
      axr(acm_pkg::ADDR_MISS);
      chk("miss_rst", rd, 32'h0);
      axr(12'hFFC);
      chk("rresp", rs, acm_pkg::RESP_DECERR);
      axw(12'hFFC, 32'hFF);
      chk("bresp", rs, acm_pkg::RESP_DECERR);
      axw(acm_pkg::ADDR_DIVM, 32'h3C);
      st <= 4'hE;
      axw(acm_pkg::ADDR_CTRL, 32'h7F);
      st <= 4'hF;
      axr(acm_pkg::ADDR_CTRL);
      chk("strb0", rd, 32'h0);
      repeat (400) @(posedge aclk);
      foreach (rows[i]) begin
         axw(acm_pkg::ADDR_CTRL, {24'h0, rows[i].ctrl});
         flt <= rows[i].flt;
         repeat (4) @(posedge aclk);
         chk("clk_error", clk_error, rows[i].err);
         chk("lock_flag", pll_lock_flag, !rows[i].flt[0]);
         chk("autoset", autoset_active, !rows[i].ctrl[1]);
         chk("div", divider_value, rows[i].ctrl[1] ? 32'h3C : 32'hA5);
         axr(acm_pkg::ADDR_CTRL);
         chk("ctrl", rd, {25'h0, rows[i].ctrl[6:0]});
      end
      // bit clocks per frame at and past both limits, then ignored
      flt <= 4'h0;
      for (int k = 0; k < 5; k++) begin
         axw(acm_pkg::ADDR_CTRL, (k == 4) ? 32'h20 : 32'h0);
         bits <= sb[k];
         repeat (1600) @(posedge aclk);
         chk("sclk_err", clk_error, se[k]);
      end
      bits <= 10'h040;
      repeat (1200) @(posedge aclk);
      axr(acm_pkg::ADDR_EVENT);
      chk("events", rd, 32'hD);
      // clocks stop: powerdown after two units, interrupt once unmasked
      axw(acm_pkg::ADDR_MISS, 32'h1);
      run <= 1'h0;
      repeat (90) @(posedge aclk);
      chk("pdn_early", dac_powerdown, 1'h0);
      repeat (20) @(posedge aclk);
      chk("pdn", dac_powerdown, 1'h1);
      chk("irq_masked", irq, 1'h0);
      axw(acm_pkg::ADDR_MASK, 32'h2);
      repeat (2) @(posedge aclk);
      chk("irq", irq, 1'h1);
      axr(acm_pkg::ADDR_EVENT);
      chk("event_pdn", rd, 32'h2);
      repeat (2) @(posedge aclk);
      chk("irq_clear", irq, 1'h0);
      axw(acm_pkg::ADDR_CTRL, 32'h4);
      repeat (3) @(posedge aclk);
      chk("pdn_ignored", dac_powerdown, 1'h0);
      run <= 1'h1;
      print_verdict;
   end
endmodule
